// [rtl/chan_out_cell.sv]
`timescale 1ns/1ps
module chan_out_cell #(
   parameter int SET_DELAY = tmr_out_pkg::SET_DELAY_CLK
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // settings
   input  wire logic chan_en,
   input  wire logic chan_pol,
   input  wire logic chan_mode,
   // timer events
   input  wire logic irq,
   input  wire logic master_irq,
   // software write of the output bit
   input  wire logic sw_we,
   input  wire logic sw_bit,
   // state
   output logic      out_ff,
   output logic      pol_eff_ff
);

   logic [SET_DELAY-1:0] set_pipe_ff;
   logic [SET_DELAY-1:0] nxt_set_pipe;
   logic                 set_c;
   logic                 rst_c;
   logic                 tog_c;
   logic                 hw_upd;
   logic                 hw_lvl;
   logic                 nxt_out;
   logic                 nxt_pol_eff;

   // ------------------------------------------------------------------
   // event decode
   // ------------------------------------------------------------------
   if (SET_DELAY > 1) begin : g_long
      assign nxt_set_pipe = {set_pipe_ff[SET_DELAY-2:0], master_irq & chan_mode};
   end else begin : g_short
      assign nxt_set_pipe = master_irq & chan_mode;
   end
   assign set_c   = chan_mode & set_pipe_ff[SET_DELAY-1];
   assign rst_c   = chan_mode & irq;
   assign tog_c   = ~chan_mode & irq;
   assign hw_upd  = chan_en & (set_c | rst_c | tog_c);
   // reset level is the polarity, set level its inverse; reset wins
   assign hw_lvl  = tog_c ? ~out_ff : (rst_c ? chan_pol : ~chan_pol);
   // the timer update has precedence over a colliding software write
   assign nxt_out = hw_upd ? hw_lvl : (sw_we ? sw_bit : out_ff);
   assign nxt_pol_eff = (hw_upd & chan_mode) ? chan_pol : pol_eff_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         set_pipe_ff <= '0;
         out_ff      <= 1'b0;
         pol_eff_ff  <= 1'b0;
      end else begin
         set_pipe_ff <= nxt_set_pipe;
         out_ff      <= nxt_out;
         pol_eff_ff  <= nxt_pol_eff;
      end
   end

endmodule // chan_out_cell

// [rtl/tmr_out_ctl.sv]
`timescale 1ns/1ps
module tmr_out_ctl (
   // clock and reset
   input  wire logic                              clk,
   input  wire logic                              rst,
   // register port
   input  wire tmr_out_pkg::bus_req_t             bus,
   output logic [tmr_out_pkg::DATA_W-1:0]         rdata_ff,
   // timer events from the channel counters
   input  wire tmr_out_pkg::timer_event_t         ev,
   // channel pins
   output logic [tmr_out_pkg::NCH-1:0]            tout,
   output logic [tmr_out_pkg::NCH-1:0]            tout_oe
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   localparam int N = tmr_out_pkg::NCH;

   logic [N-1:0]                   oe_ff;
   logic [N-1:0]                   pol_ff;
   logic [N-1:0]                   mode_ff;
   logic [N-1:0]                   nxt_oe;
   logic [N-1:0]                   nxt_pol;
   logic [N-1:0]                   nxt_mode;
   logic [N-1:0]                   out_bits;
   logic [N-1:0]                   pol_eff;
   logic [tmr_out_pkg::DATA_W-1:0] nxt_rdata;
   logic [tmr_out_pkg::DATA_W-1:0] rd_mux;
   logic [N-1:0]                   wd_ch;
   logic                           wr_out;
   logic                           wr_oe;
   logic                           wr_pol;
   logic                           wr_mode;
   logic                           rd_out;
   logic                           rd_oe;
   logic                           rd_pol;
   logic                           rd_mode;
   logic                           rd_app;

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   assign wd_ch   = bus.wdata[tmr_out_pkg::CH_MSB:tmr_out_pkg::CH_LSB];
   assign wr_out  = bus.wr & tmr_out_pkg::reg_hit(bus.addr, tmr_out_pkg::OFF_OUT);
   assign wr_oe   = bus.wr & tmr_out_pkg::reg_hit(bus.addr, tmr_out_pkg::OFF_OE);
   assign wr_pol  = bus.wr & tmr_out_pkg::reg_hit(bus.addr, tmr_out_pkg::OFF_POL);
   assign wr_mode = bus.wr & tmr_out_pkg::reg_hit(bus.addr, tmr_out_pkg::OFF_MODE);
   assign rd_out  = bus.rd & tmr_out_pkg::reg_hit(bus.addr, tmr_out_pkg::OFF_OUT);
   assign rd_oe   = bus.rd & tmr_out_pkg::reg_hit(bus.addr, tmr_out_pkg::OFF_OE);
   assign rd_pol  = bus.rd & tmr_out_pkg::reg_hit(bus.addr, tmr_out_pkg::OFF_POL);
   assign rd_mode = bus.rd & tmr_out_pkg::reg_hit(bus.addr, tmr_out_pkg::OFF_MODE);
   assign rd_app  = bus.rd & tmr_out_pkg::reg_hit(bus.addr, tmr_out_pkg::OFF_APPLIED);

   // ------------------------------------------------------------------
   // settings registers
   // ------------------------------------------------------------------
   // settings act on the very next clock, no shadowing
   assign nxt_oe   = wr_oe ? wd_ch : oe_ff;
   assign nxt_pol  = wr_pol ? wd_ch : pol_ff;
   // upper mode bits are kept zero by software and not stored
   assign nxt_mode = wr_mode ? wd_ch : mode_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         oe_ff   <= tmr_out_pkg::RST_OE;
         pol_ff  <= tmr_out_pkg::RST_POL;
         mode_ff <= tmr_out_pkg::RST_MODE;
      end else begin
         oe_ff   <= nxt_oe;
         pol_ff  <= nxt_pol;
         mode_ff <= nxt_mode;
      end
   end

   // ------------------------------------------------------------------
   // read port
   // ------------------------------------------------------------------
   // read data stand one cycle only; unmapped offsets answer zero
   assign rd_mux = rd_out  ? {{(tmr_out_pkg::DATA_W-N){1'b0}}, out_bits} :
                   rd_oe   ? {{(tmr_out_pkg::DATA_W-N){1'b0}}, oe_ff}    :
                   rd_pol  ? {{(tmr_out_pkg::DATA_W-N){1'b0}}, pol_ff}   :
                   rd_mode ? {{(tmr_out_pkg::DATA_W-N){1'b0}}, mode_ff}  :
                   rd_app  ? {{(tmr_out_pkg::DATA_W-N){1'b0}}, pol_eff}  :
                   tmr_out_pkg::RD_IDLE;
   assign nxt_rdata = rd_mux;

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= tmr_out_pkg::RD_IDLE;
         tout_oe  <= tmr_out_pkg::RST_OE;
      end else begin
         rdata_ff <= nxt_rdata;
         tout_oe  <= nxt_oe;
      end
   end

   // ------------------------------------------------------------------
   // channel output cells
   // ------------------------------------------------------------------
   // the cells see only settings, interrupts and the software output write, never the counters
   for (genvar n = 0; n < N; n++) begin : g_ch
      chan_out_cell #(
         .SET_DELAY (tmr_out_pkg::SET_DELAY_CLK)
      ) u_cell (
         .clk        (clk),
         .rst        (rst),
         .chan_en    (oe_ff[n]),
         .chan_pol   (pol_ff[n]),
         .chan_mode  (mode_ff[n]),
         .irq        (ev.irq[n]),
         .master_irq (ev.master_irq[n]),
         .sw_we      (wr_out),
         .sw_bit     (wd_ch[n]),
         .out_ff     (out_bits[n]),
         .pol_eff_ff (pol_eff[n])
      );
   end

   assign tout = out_bits;

   // ------------------------------------------------------------------
   // register port checks
   // ------------------------------------------------------------------
   property p_rd_once;
      @(posedge clk) disable iff (rst)
      !bus.rd |=> (rdata_ff == tmr_out_pkg::RD_IDLE);
   endproperty
   a_rd_once: assert property (p_rd_once)
      else $error("read data present without a read");

   property p_oe_wr;
      @(posedge clk) disable iff (rst)
      wr_oe |=> (oe_ff == $past(wd_ch)) && (tout_oe == $past(wd_ch));
   endproperty
   a_oe_wr: assert property (p_oe_wr)
      else $error("enable write not applied at once");

   property p_mode_rd;
      @(posedge clk) disable iff (rst)
      rd_mode |=> (rdata_ff[tmr_out_pkg::DATA_W-1:N] == '0)
                  && (rdata_ff[N-1:0] == mode_ff);
   endproperty
   a_mode_rd: assert property (p_mode_rd)
      else $error("mode readback wrong");

   property p_pol_wr;
      @(posedge clk) disable iff (rst)
      wr_pol |=> (pol_ff == $past(wd_ch));
   endproperty
   a_pol_wr: assert property (p_pol_wr)
      else $error("polarity write not applied at once");

   property p_mode_wr;
      @(posedge clk) disable iff (rst)
      wr_mode |=> (mode_ff == $past(wd_ch));
   endproperty
   a_mode_wr: assert property (p_mode_wr)
      else $error("mode write not applied at once");

   property p_oe_keep;
      @(posedge clk) disable iff (rst)
      !wr_oe |=> $stable(oe_ff) && (tout_oe == oe_ff);
   endproperty
   a_oe_keep: assert property (p_oe_keep)
      else $error("enable moved without a write");

   property p_out_rd;
      @(posedge clk) disable iff (rst)
      rd_out |=> (rdata_ff == {{(tmr_out_pkg::DATA_W-N){1'b0}}, $past(tout)});
   endproperty
   a_out_rd: assert property (p_out_rd)
      else $error("output bit readback wrong");

   property p_app_rd;
      @(posedge clk) disable iff (rst)
      rd_app |=> (rdata_ff == {{(tmr_out_pkg::DATA_W-N){1'b0}}, $past(pol_eff)});
   endproperty
   a_app_rd: assert property (p_app_rd)
      else $error("applied polarity readback wrong");

   // ------------------------------------------------------------------
   // per-channel output checks
   // ------------------------------------------------------------------
   for (genvar n = 0; n < N; n++) begin : g_chk

      property p_toggle;
         @(posedge clk) disable iff (rst)
         (oe_ff[n] && !mode_ff[n] && ev.irq[n])
            |=> (tout[n] == !$past(tout[n]));
      endproperty
      a_toggle: assert property (p_toggle)
         else $error("toggle event did not invert the pin");

      property p_tog_nopol;
         @(posedge clk) disable iff (rst)
         (!mode_ff[n] && !ev.irq[n] && !wr_out)
            |=> $stable(tout[n]) && $stable(pol_eff[n]);
      endproperty
      a_tog_nopol: assert property (p_tog_nopol)
         else $error("toggle mode pin moved without an event");

      property p_rst_lvl;
         @(posedge clk) disable iff (rst)
         (oe_ff[n] && mode_ff[n] && ev.irq[n])
            |=> (tout[n] == $past(pol_ff[n]));
      endproperty
      a_rst_lvl: assert property (p_rst_lvl)
         else $error("reset did not give the inactive level");

      property p_set_late;
         @(posedge clk) disable iff (rst)
         (oe_ff[n] && mode_ff[n] && ev.master_irq[n])
            ##1 (oe_ff[n] && mode_ff[n] && !ev.irq[n])
            |=> (tout[n] == !$past(pol_ff[n]));
      endproperty
      a_set_late: assert property (p_set_late)
         else $error("delayed set did not give the active level");

      property p_no_early_set;
         @(posedge clk) disable iff (rst)
         (oe_ff[n] && mode_ff[n] && ev.master_irq[n] && !ev.irq[n]
            && !wr_out && !$past(ev.master_irq[n]))
            |=> $stable(tout[n]);
      endproperty
      a_no_early_set: assert property (p_no_early_set)
         else $error("set acted without the one-clock delay");

      property p_pol_pending;
         @(posedge clk) disable iff (rst)
         (wr_pol && !ev.irq[n] && !ev.master_irq[n] && !wr_out)
            ##1 (!ev.irq[n] && !wr_out && !g_ch[n].u_cell.set_c)
            |=> $stable(tout[n]) && $stable(pol_eff[n]);
      endproperty
      a_pol_pending: assert property (p_pol_pending)
         else $error("polarity applied before a change condition");

      property p_pol_write;
         @(posedge clk) disable iff (rst)
         (wr_pol && !ev.irq[n] && !wr_out && !g_ch[n].u_cell.set_c)
            |=> $stable(tout[n]);
      endproperty
      a_pol_write: assert property (p_pol_write)
         else $error("polarity write moved the pin");

      property p_pol_apply;
         @(posedge clk) disable iff (rst)
         (oe_ff[n] && mode_ff[n] && ev.irq[n])
            |=> (pol_eff[n] == $past(pol_ff[n]));
      endproperty
      a_pol_apply: assert property (p_pol_apply)
         else $error("active level not taken at change condition");

      property p_preset;
         @(posedge clk) disable iff (rst)
         (!oe_ff[n] && wr_out) |=> (tout[n] == $past(wd_ch[n]));
      endproperty
      a_preset: assert property (p_preset)
         else $error("preset level not written while disabled");

      property p_disabled;
         @(posedge clk) disable iff (rst)
         (!oe_ff[n] && !wr_out) |=> $stable(tout[n]);
      endproperty
      a_disabled: assert property (p_disabled)
         else $error("timer event changed a disabled output");

      property p_collide;
         @(posedge clk) disable iff (rst)
         (oe_ff[n] && !mode_ff[n] && ev.irq[n] && wr_out)
            |=> (tout[n] == !$past(tout[n]));
      endproperty
      a_collide: assert property (p_collide)
         else $error("timer update lost against a software write");

      property p_sw_write;
         @(posedge clk) disable iff (rst)
         (oe_ff[n] && wr_out && !ev.irq[n] && !g_ch[n].u_cell.set_c)
            |=> (tout[n] == $past(wd_ch[n]));
      endproperty
      a_sw_write: assert property (p_sw_write)
         else $error("software write lost with the output enabled");

      property p_set_collide;
         @(posedge clk) disable iff (rst)
         (oe_ff[n] && g_ch[n].u_cell.set_c && !ev.irq[n] && wr_out)
            |=> (tout[n] == !$past(pol_ff[n]));
      endproperty
      a_set_collide: assert property (p_set_collide)
         else $error("delayed set lost against a software write");

      property p_rst_collide;
         @(posedge clk) disable iff (rst)
         (oe_ff[n] && mode_ff[n] && ev.irq[n] && wr_out)
            |=> (tout[n] == $past(pol_ff[n]));
      endproperty
      a_rst_collide: assert property (p_rst_collide)
         else $error("reset lost against a software write");

      property p_both;
         @(posedge clk) disable iff (rst)
         (oe_ff[n] && mode_ff[n] && ev.irq[n] && g_ch[n].u_cell.set_c)
            |=> (tout[n] == $past(pol_ff[n])) && (pol_eff[n] == $past(pol_ff[n]));
      endproperty
      a_both: assert property (p_both)
         else $error("set beat a reset in the same cycle");

      property p_pol_hold;
         @(posedge clk) disable iff (rst)
         (!ev.irq[n] && !g_ch[n].u_cell.set_c) |=> $stable(pol_eff[n]);
      endproperty
      a_pol_hold: assert property (p_pol_hold)
         else $error("applied polarity moved without a change condition");

      property p_tog_pol;
         @(posedge clk) disable iff (rst)
         !mode_ff[n] |=> $stable(pol_eff[n]);
      endproperty
      a_tog_pol: assert property (p_tog_pol)
         else $error("toggle mode took up the polarity");

      property p_enable_rise;
         @(posedge clk) disable iff (rst)
         ($rose(oe_ff[n]) && !ev.irq[n] && !g_ch[n].u_cell.set_c && !wr_out)
            |=> $stable(tout[n]);
      endproperty
      a_enable_rise: assert property (p_enable_rise)
         else $error("enabling moved the preset level");

      property p_set_cause;
         @(posedge clk) disable iff (rst)
         g_ch[n].u_cell.set_c |-> $past(ev.master_irq[n], tmr_out_pkg::SET_DELAY_CLK);
      endproperty
      a_set_cause: assert property (p_set_cause)
         else $error("set raised without a master event");

      property p_mst_pipe;
         @(posedge clk) disable iff (rst)
         (ev.master_irq[n] && mode_ff[n]) |=> g_ch[n].u_cell.set_pipe_ff[0];
      endproperty
      a_mst_pipe: assert property (p_mst_pipe)
         else $error("master event not queued for the delayed set");

      property p_dis_pol;
         @(posedge clk) disable iff (rst)
         !oe_ff[n] |=> $stable(pol_eff[n]);
      endproperty
      a_dis_pol: assert property (p_dis_pol)
         else $error("timer event acted on a disabled channel");

   end

endmodule // tmr_out_ctl

// [rtl/tmr_out_pkg.sv]
// Notes on behaviour
// - Rewriting output, enable, polarity or mode never disturbs any counter or compare.
// - Enable, polarity and mode writes take effect at once, even beside an interrupt.
// - A level written to the output bit while disabled is where the pin starts once enabled.
// - In toggle mode the polarity bit is ignored.
// - In toggle mode each own-channel interrupt inverts the current pin level.
// - In combined mode the polarity bit selects which pin level is active.
// - In combined mode a polarity change waits for the next set or reset to apply.
// - Writing the polarity bit alone never changes the pin level.
// - In combined mode the set from the master interrupt lands one count clock late.
// - A reset and a set in the same cycle give reset.
// - With the enable at 1 a timer update colliding with a software write still reaches the pin.
package tmr_out_pkg;

   // ------------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------------
   localparam int NCH    = 8;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 3;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_OUT     = 3'h0;
   localparam logic [ADDR_W-1:0] OFF_OE      = 3'h1;
   localparam logic [ADDR_W-1:0] OFF_POL     = 3'h2;
   localparam logic [ADDR_W-1:0] OFF_MODE    = 3'h3;
   localparam logic [ADDR_W-1:0] OFF_APPLIED = 3'h4;

   // ------------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------------
   localparam int CH_LSB = 0;
   localparam int CH_MSB = 7;
   localparam logic [NCH-1:0] RST_OUT  = 8'h00;
   localparam logic [NCH-1:0] RST_OE   = 8'h00;
   localparam logic [NCH-1:0] RST_POL  = 8'h00;
   localparam logic [NCH-1:0] RST_MODE = 8'h00;
   localparam logic [DATA_W-1:0] RD_IDLE = 16'h0000;

   // ------------------------------------------------------------------
   // timing in count clocks
   // ------------------------------------------------------------------
   localparam int SET_DELAY_CLK = 1;
   localparam int RD_LATENCY    = 1;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic [NCH-1:0] irq;
      logic [NCH-1:0] master_irq;
   } timer_event_t;

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
      reg_hit = (a == off);
   endfunction

endpackage

// [verif/chan_ctr_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// master and slave channel counters, reduced to their interrupt pulses
// ------------------------------------------------------------------
module chan_ctr_model (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // requested pulses and answer speed
   input  wire logic [tmr_out_pkg::NCH-1:0]   trig_irq,
   input  wire logic [tmr_out_pkg::NCH-1:0]   trig_mst,
   input  wire logic                          slow,
   // events towards the output control
   output tmr_out_pkg::timer_event_t          ev
);
   logic [3:0][2*tmr_out_pkg::NCH-1:0] pipe_ff;

   // slave count match resets, master count match sets; slow adds three count clocks
   always_ff @(posedge clk) begin
      if (rst) begin
         pipe_ff <= '0;
      end else begin
         pipe_ff <= {pipe_ff[2:0], {trig_irq, trig_mst}};
      end
   end

   assign ev = slow ? pipe_ff[3] : pipe_ff[0];
endmodule // chan_ctr_model

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
   logic                   clk = 1'b0;
   logic                   rst = 1'b1;
   tmr_out_pkg::bus_req_t  bus = '0;
   logic [15:0]            rdata_ff;
   tmr_out_pkg::timer_event_t ev;
   logic [7:0]             tout, tout_oe, trig_irq = 8'h00, trig_mst = 8'h00;
   logic                   slow = 1'b0;
   logic [7:0]             e_out, e_en, e_pol, e_mode, e_ap, e_pend, n_out;
   logic [15:0]            e_rd;
   int                     n_fail = 0, total_checks = 0, cyc = 0, seed = 14, r;

   always #25 clk = ~clk;

   chan_ctr_model chan_ctr_model_i (.clk(clk), .rst(rst), .trig_irq(trig_irq),
      .trig_mst(trig_mst), .slow(slow), .ev(ev));
   tmr_out_ctl tmr_out_ctl_i (.clk(clk), .rst(rst), .bus(bus), .rdata_ff(rdata_ff),
      .ev(ev), .tout(tout), .tout_oe(tout_oe));

   // ------------------------------------------------------------------
   // expected behaviour
   // ------------------------------------------------------------------
   function automatic logic next_out(input logic en, pol, mode, o, irq, set, we, wb);
      if (en && !mode && irq) return ~o;
      if (en && mode && irq) return pol;
      if (en && mode && set) return ~pol;
      if (we) return wb;
      return o;
   endfunction

   function automatic logic [7:0] rd_val(input logic [2:0] a);
      case (a)
         tmr_out_pkg::OFF_OUT:     return e_out;
         tmr_out_pkg::OFF_OE:      return e_en;
         tmr_out_pkg::OFF_POL:     return e_pol;
         tmr_out_pkg::OFF_MODE:    return e_mode;
         tmr_out_pkg::OFF_APPLIED: return e_ap;
         default:                  return 8'h00;
      endcase
   endfunction

   always @(posedge clk) begin
      if (rst) begin
         {e_out, e_en, e_pol, e_mode, e_ap, e_pend, e_rd} = '0;
      end else begin
         e_rd = bus.rd ? {8'h00, rd_val(bus.addr)} : 16'h0000;
         for (int n = 0; n < 8; n++) begin
            n_out[n] = next_out(e_en[n], e_pol[n], e_mode[n], e_out[n], ev.irq[n],
               e_pend[n], bus.wr && bus.addr == tmr_out_pkg::OFF_OUT, bus.wdata[n]);
            if (e_en[n] && e_mode[n] && (ev.irq[n] || e_pend[n])) e_ap[n] = e_pol[n];
         end
         e_pend = ev.master_irq & e_mode;
         e_out = n_out;
         if (bus.wr && bus.addr == tmr_out_pkg::OFF_OE) e_en = bus.wdata[7:0];
         if (bus.wr && bus.addr == tmr_out_pkg::OFF_POL) e_pol = bus.wdata[7:0];
         if (bus.wr && bus.addr == tmr_out_pkg::OFF_MODE) e_mode = bus.wdata[7:0];
      end
   end

   // ------------------------------------------------------------------
   // checking and reporting
   // ------------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(negedge clk) begin
      if (!rst) begin
         chk("tout", {8'h00, e_out}, {8'h00, tout});
         chk("tout_oe", {8'h00, e_en}, {8'h00, tout_oe});
         chk("rdata", e_rd, rdata_ff);
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end

   // ------------------------------------------------------------------
   // bus and event drivers
   // ------------------------------------------------------------------
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      bus <= '{1'b1, 1'b0, a, {8'h00, v}};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a);
      @(posedge clk);
      bus <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge clk);
      bus.rd <= 1'b0;
   endtask

   task automatic fire(input logic [7:0] iv, input logic [7:0] mv, input int len);
      @(posedge clk);
      trig_irq <= iv;
      trig_mst <= mv;
      repeat (len) @(posedge clk);
      trig_irq <= 8'h00;
      trig_mst <= 8'h00;
      repeat (6) @(posedge clk);
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) rd_reg(a[2:0]); // reset values and unmapped offsets
      // preset while disabled, events ignored, then enable
      wr_reg(tmr_out_pkg::OFF_OUT, 8'ha5);
      fire(8'hff, 8'hff, 1);
      wr_reg(tmr_out_pkg::OFF_OE, 8'hff);
      // toggle mode with polarity set, back-to-back toggles
      wr_reg(tmr_out_pkg::OFF_POL, 8'hff);
      for (int k = 1; k < 4; k++) fire(8'hff, 8'h00, k);
      // combined mode: set, reset, then set and reset landing together
      wr_reg(tmr_out_pkg::OFF_MODE, 8'hff);
      wr_reg(tmr_out_pkg::OFF_POL, 8'h0f);
      fire(8'h00, 8'hff, 1);
      fire(8'hff, 8'h00, 1);
      @(posedge clk);
      trig_mst <= 8'h3c;
      @(posedge clk);
      trig_mst <= 8'h00;
      trig_irq <= 8'h0f;
      fire(8'h00, 8'h00, 1);
      // polarity change held until the next set or reset
      wr_reg(tmr_out_pkg::OFF_POL, 8'hf0);
      rd_reg(tmr_out_pkg::OFF_APPLIED);
      fire(8'h00, 8'hff, 1);
      rd_reg(tmr_out_pkg::OFF_APPLIED);
      // mixed modes, random events against software traffic, prompt and slow
      wr_reg(tmr_out_pkg::OFF_MODE, 8'hf0);
      wr_reg(tmr_out_pkg::OFF_OE, 8'hcc);
      wr_reg(tmr_out_pkg::OFF_POL, 8'ha5);
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            r = $random(seed);
            trig_irq <= r[7:0];
            trig_mst <= r[15:8];
            bus <= '{r[16], ~r[16] & r[17], r[16] ? 3'h0 : r[20:18], {8'h00, r[31:24]}};
         end
         @(posedge clk);
         bus <= '0;
         fire(8'h00, 8'h00, 1);
      end
      close_out();
   end
endmodule // testbench
